// file: hdl/parallel_config_loader.v
// Device-side passive parallel configuration loader
// Assumes the host drives load_clock, data and reconfig_request_n;
// all pins are sampled into the clk_i domain through two flip-flops.
// Load clock must stay high and low for at least three clk_i periods;
// words pass straight to word_o, with no buffering behind them.
// Overview of operation
// R01 - Low reconfiguration request abandons user mode and restarts configuration.
// R02 - In user mode status and load-complete outputs stay high.
// R03 - Status held low for the power-on-reset delay after power-up.
// R04 - Load-complete low from power-up through loading until configuration ends.
// R05 - After completion, load clock activity is ignored entirely.
// R06 - Host keeps load clock at a defined level after configuration.
// R07 - Host may pause by holding load clock low; no data lost.
// R08 - Host presents valid data before first rising edge on resume.
// R09 - Each 32-bit word is held for r load clock cycles.
// R10 - Host must deliver the complete image.
// R11 - Load-complete rises only after the whole image arrives without error.
// R12 - Host then gives two falling load clock edges to start initialization.
// R13 - If option bit loaded, initialization-done output driven low.
// R14 - Host waits for status high before first word and edge.
// R15 - Clock-to-data ratio r is a build-time parameter.
`timescale 1ns/100ps
`include "cfg_loader_defines.vh"
module parallel_config_loader #(
  parameter RATIO = `DEF_RATIO, // R15
  parameter IMAGE_WORDS = `DEF_IMAGE_WORDS,
  parameter POR_CYCLES = `POR_CYCLES,
  parameter DATA_W = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Host pins
  input wire reconfig_request_n_i,
  input wire load_clock_i,
  input wire [DATA_W-1:0] data_i,
  // Status pins
  output reg device_status_n_o,
  output reg load_complete_o,
  output reg init_done_o,
  output reg init_done_oe_o,
  output reg user_mode_o,
  output reg error_o,
  // Received words to the configuration memory
  output reg [DATA_W-1:0] word_o,
  output reg word_valid_o
);
  localparam ST_POR = 5'h01;
  localparam ST_CLEAR = 5'h02;
  localparam ST_LOAD = 5'h04;
  localparam ST_INIT = 5'h08;
  localparam ST_USER = 5'h10;

  // Counter limits cut once to the counter width
  localparam [`CNT_W-1:0] POR_LIM = POR_CYCLES[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RATIO_LIM = RATIO[`CNT_W-1:0];
  localparam [`CNT_W-1:0] WORDS_LIM = IMAGE_WORDS[`CNT_W-1:0];

  // Sequencer state and counters
  reg [4:0] state_r;
  reg [`CNT_W-1:0] por_cnt_r;
  reg [`CNT_W-1:0] word_cnt_r;
  reg [`CNT_W-1:0] ratio_cnt_r;
  reg [1:0] fall_cnt_r;
  // Pin samples
  reg [DATA_W-1:0] data_s1_r;
  reg [DATA_W-1:0] data_s2_r;
  reg init_opt_r;
  wire req_n_s;
  wire clk_rise;
  wire clk_fall;

  function last_of;
    input [`CNT_W-1:0] cnt;
    input [`CNT_W-1:0] limit;
    begin
      last_of = (cnt == limit - `ONE_CNT);
    end
  endfunction

  pin_sync u_req_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reset_level_i(1'b0),
    .pin_i(reconfig_request_n_i),
    .level_o(req_n_s),
    .rise_o(),
    .fall_o()
  );

  pin_sync u_clk_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reset_level_i(1'b0),
    .pin_i(load_clock_i),
    .level_o(),
    .rise_o(clk_rise),
    .fall_o(clk_fall)
  );

  // Data passes two stages so it lines up with the synchronised edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_s1_r <= {DATA_W{1'b0}};
      data_s2_r <= {DATA_W{1'b0}};
    end else begin
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_POR;
      por_cnt_r <= `ZERO_CNT;
      word_cnt_r <= `ZERO_CNT;
      ratio_cnt_r <= `ZERO_CNT;
      fall_cnt_r <= 2'h0;
      init_opt_r <= 1'b0;
      device_status_n_o <= 1'b0;
      load_complete_o <= 1'b0;
      init_done_o <= 1'b0;
      init_done_oe_o <= 1'b0;
      user_mode_o <= 1'b0;
      error_o <= 1'b0;
      word_o <= {DATA_W{1'b0}};
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      case (state_r)
        ST_POR: begin
          device_status_n_o <= 1'b0; // R03
          load_complete_o <= 1'b0; // R04
          // Request pin is not looked at until the delay has run out
          if (last_of(por_cnt_r, POR_LIM)) begin
            state_r <= ST_CLEAR;
          end else begin
            por_cnt_r <= por_cnt_r + `ONE_CNT;
          end
        end

        ST_CLEAR: begin
          // Request held low keeps the device in clearing
          load_complete_o <= 1'b0; // R04
          user_mode_o <= 1'b0;
          init_done_o <= 1'b0;
          init_done_oe_o <= 1'b0;
          if (req_n_s) begin
            device_status_n_o <= 1'b1;
            word_cnt_r <= `ZERO_CNT;
            ratio_cnt_r <= `ZERO_CNT;
            fall_cnt_r <= 2'h0;
            init_opt_r <= 1'b0;
            state_r <= ST_LOAD;
          end
        end

        ST_LOAD: begin
          // Abort drops any partly held word
          if (!req_n_s) begin
            state_r <= ST_CLEAR; // R01
            device_status_n_o <= 1'b0;
          end else if (clk_rise) begin
            // A paused clock simply yields no edges; nothing is lost
            if (last_of(ratio_cnt_r, RATIO_LIM)) begin // R09
              ratio_cnt_r <= `ZERO_CNT;
              word_o <= data_s2_r;
              word_valid_o <= 1'b1;
              if (word_cnt_r == `ZERO_CNT) begin
                init_opt_r <= data_s2_r[`INIT_OPT_BIT];
                // Option pin is pulled low as soon as its bit is in
                init_done_oe_o <= data_s2_r[`INIT_OPT_BIT]; // R13
                init_done_o <= 1'b0;
              end
              if (last_of(word_cnt_r, WORDS_LIM)) begin
                load_complete_o <= 1'b1; // R11
                state_r <= ST_INIT;
              end
              word_cnt_r <= word_cnt_r + `ONE_CNT;
            end else begin
              ratio_cnt_r <= ratio_cnt_r + `ONE_CNT;
            end
          end
        end

        ST_INIT: begin
          // Only falls seen after load-complete rose are counted
          if (!req_n_s) begin
            state_r <= ST_CLEAR;
            device_status_n_o <= 1'b0;
            load_complete_o <= 1'b0;
          end else if (clk_fall) begin
            if (fall_cnt_r == `INIT_EDGES - 2'h1) begin // R12
              state_r <= ST_USER;
              user_mode_o <= 1'b1;
              if (init_opt_r) begin
                init_done_o <= 1'b1;
              end
            end
            fall_cnt_r <= fall_cnt_r + 2'h1;
          end
        end

        ST_USER: begin
          // Load clock edges are no longer looked at here
          device_status_n_o <= 1'b1; // R02
          load_complete_o <= 1'b1; // R05
          if (!req_n_s) begin
            state_r <= ST_CLEAR; // R01
            device_status_n_o <= 1'b0;
            load_complete_o <= 1'b0;
            user_mode_o <= 1'b0;
            init_done_o <= 1'b0;
            init_done_oe_o <= 1'b0;
          end
        end

        default: begin
          state_r <= ST_POR;
          error_o <= 1'b1;
        end
      endcase
    end
  end
endmodule

// file: hdl/cfg_loader_defines.vh
// Constants for the passive parallel configuration loader
// Assumes inclusion by bare name from design files in hdl/
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH
`define POR_DELAY_NS 1000
`define CLK_PERIOD_NS 8
`define POR_CYCLES ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEF_RATIO 1
`define DEF_IMAGE_WORDS 16
`define INIT_EDGES 2'h2
`define INIT_OPT_BIT 0
`define CNT_W 24
`define ONE_CNT 24'h00_0001
`define ZERO_CNT 24'h00_0000
`endif

// file: hdl/pin_sync.v
// Two-flop synchroniser with edge detection on the second stage
// Assumes an asynchronous pin and a single system clock
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire reset_level_i,
  // Pin
  input wire pin_i,
  // Synchronised level and edges
  output reg level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r;
  reg prev_r;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      level_o <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      level_o <= meta_r;
      prev_r <= level_o;
    end
  end

  // Reset level is not loaded at reset; driven high it suppresses every edge report
  assign rise_o = level_o & ~prev_r & ~reset_level_i;
  assign fall_o = ~level_o & prev_r & ~reset_level_i;
endmodule

// file: bench/parallel_config_loader_properties.sv
// Port checker for the parallel configuration loader
// Assumes binding into parallel_config_loader, one clock domain
`timescale 1ns/100ps
module parallel_config_loader_properties #(
  parameter RATIO = 1,
  parameter IMAGE_WORDS = 16,
  parameter POR_CYCLES = 125,
  parameter DATA_W = 32
) (
  // Clock, reset and host pins
  input wire clk_i,
  input wire rst_n_i,
  input wire reconfig_request_n_i,
  input wire load_clock_i,
  input wire [DATA_W-1:0] data_i,
  // Outputs
  input wire [DATA_W-1:0] word_o,
  input wire device_status_n_o,
  input wire load_complete_o,
  input wire init_done_o,
  input wire init_done_oe_o,
  input wire user_mode_o,
  input wire error_o,
  input wire word_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [15:0] por_n, wc;
  reg opt_r;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_n <= 16'h0000;
      wc <= 16'h0000;
      opt_r <= 1'b0;
    end else begin
      por_n <= por_n + {15'h0000, ~&por_n};
      wc <= !device_status_n_o ? 16'h0000 : wc + {15'h0000, word_valid_o};
      if (word_valid_o && wc == 16'h0000) opt_r <= word_o[0];
    end
  end
  property p_req; $fell(reconfig_request_n_i) |-> ##[1:4] !device_status_n_o && !user_mode_o;
  endproperty
  a_req: assert property (p_req) else $error("request low not obeyed");
  property p_usr; user_mode_o |-> device_status_n_o && load_complete_o; endproperty
  a_usr: assert property (p_usr) else $error("user mode pins not high");
  property p_por; por_n < POR_CYCLES - 1 |-> !device_status_n_o; endproperty
  a_por: assert property (p_por) else $error("status released early");
  property p_lcl; !device_status_n_o |-> !load_complete_o; endproperty
  a_lcl: assert property (p_lcl) else $error("load complete high too soon");
  property p_idle; (user_mode_o && reconfig_request_n_i)[*3] |=>
    user_mode_o && !word_valid_o && $stable(word_o);
  endproperty
  a_idle: assert property (p_idle) else $error("load clock not ignored");
  property p_wv; word_valid_o |=> !word_valid_o[*5]; endproperty
  a_wv: assert property (p_wv) else $error("words too close");
  property p_full; $rose(load_complete_o) |-> wc + word_valid_o == IMAGE_WORDS; endproperty
  a_full: assert property (p_full) else $error("load complete before full image");
  property p_init; load_complete_o && !user_mode_o |-> init_done_oe_o == opt_r && !init_done_o;
  endproperty
  a_init: assert property (p_init) else $error("init done pin wrong");
endmodule
bind parallel_config_loader parallel_config_loader_properties #(.RATIO(RATIO),
  .IMAGE_WORDS(IMAGE_WORDS), .POR_CYCLES(POR_CYCLES), .DATA_W(DATA_W)) u_chk (.*);

// file: bench/cfg_host_model.sv
// Host model: load clock, data bus and reconfiguration request
// Assumes the device samples all three with its own clock
`timescale 1ns/100ps
module cfg_host_model (
  output logic reconfig_request_n_o,
  output logic load_clock_o,
  output logic [31:0] data_o
);
  initial begin
    reconfig_request_n_o = 1'b1;
    load_clock_o = 1'b0;
    data_o = 32'h0000_0000;
  end
  task automatic set_req(input logic v);
    reconfig_request_n_o = v;
  endtask
  // Released data shows the inverse so stale values never match
  task automatic send(input logic [31:0] w, input int r, input int gap);
    data_o = w;
    #37;
    repeat (r) begin
      load_clock_o = 1'b1;
      #40 load_clock_o = 1'b0;
      #40;
    end
    // Without a pause the next word follows, so data is left alone
    if (gap > 0) begin
      data_o = ~w;
      #(gap);
    end
  endtask
  // The last word's closing fall already follows load-complete,
  // so one more cycle makes exactly two falls
  task automatic tail();
    #40 load_clock_o = 1'b1;
    #40 load_clock_o = 1'b0;
  endtask
endmodule

// file: bench/parallel_config_loader_tb.sv
// Self-checking bench for the parallel configuration loader
// Assumes cfg_host_model drives the host pins
`timescale 1ns/100ps
module parallel_config_loader_tb;
  localparam int R = 2;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire req_n, lclk, st_n, lc, ido, ido_oe, um, err, wv;
  wire [31:0] din, wd;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] got[$];
  initial forever #4 clk_i = ~clk_i;
  cfg_host_model host (.reconfig_request_n_o(req_n), .load_clock_o(lclk), .data_o(din));
  parallel_config_loader #(.RATIO(R), .IMAGE_WORDS(2), .POR_CYCLES(4)) DUT (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .reconfig_request_n_i(req_n), .load_clock_i(lclk), .data_i(din),
    .device_status_n_o(st_n), .load_complete_o(lc), .init_done_o(ido),
    .init_done_oe_o(ido_oe), .user_mode_o(um), .error_o(err), .word_o(wd), .word_valid_o(wv));
  always @(posedge clk_i) if (wv === 1'b1) got.push_back(wd);
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic t_load(input logic opt, input int gap);
    got.delete();
    for (int k = 0; k < 200 && st_n !== 1'b1; k++) @(posedge clk_i) #1;
    chk(st_n, 1'b1);
    @(posedge clk_i) #1;
    host.send({31'h1234_5678, opt}, R, gap);
    chk(lc, 1'b0);
    host.send(32'ha5a5_0f0f, R, 0);
    for (int k = 0; k < 50 && lc !== 1'b1; k++) @(posedge clk_i) #1;
    chk({lc, um, ido_oe, ido}, {2'b10, opt, 1'b0});
    chk(got.size(), 2);
    chk(got[0], {31'h1234_5678, opt});
    chk(got[1], 32'ha5a5_0f0f);
    host.tail();
    for (int k = 0; k < 50 && um !== 1'b1; k++) @(posedge clk_i) #1;
    chk({um, st_n, lc, ido, err}, {3'b111, opt, 1'b0});
    $display("load test done");
  endtask
  task automatic t_ignore();
    got.delete();
    host.send(32'hdead_beef, 3, 0);
    chk(got.size(), 0);
    chk({um, lc}, 2'b11);
    chk(wd, 32'ha5a5_0f0f);
    $display("ignore test done");
  endtask
  task automatic t_reconf();
    @(posedge clk_i) #1 host.set_req(1'b0);
    repeat (8) @(posedge clk_i);
    chk({st_n, lc, um}, 3'b000);
    #1 host.set_req(1'b1);
    $display("reconfig test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk({st_n, lc}, 2'b00);
    t_load(1'b1, 400);
    t_ignore();
    t_reconf();
    t_load(1'b0, 0);
    finish_test();
  end
  // Whole sequence needs under 10 us
  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
